//--- blc_cfg.svh
// constants for the backlash compensation block
// Overview of operation
// RULE1 - compensation acts only in position control, including full-closed; never velocity or torque
// RULE2 - direction field 01b compensates on first positive motion after servo-on
// RULE3 - direction field is latched only at servo-on; later writes wait
// RULE4 - software keeps amount, time constant and hold bit still during motion
// RULE5 - compensation state is kept across velocity or torque mode, resumed after
// RULE6 - with report bit zero actual position is offset by the compensation amount
// RULE7 - first motion in selected direction adds compensation; opposite first motion adds none
// RULE8 - after initial compensation, first opposite motion applies compensation in reverse
// RULE9 - repeated motion in the last compensated direction adds nothing further
// RULE10 - hold bit zero: servo-off presets command position including offset, restart later
// RULE11 - hold bit one: state kept through servo-off and resumed at servo-on
// RULE12 - on some variants the hold bit is unsupported; software keeps it zero
// RULE13 - direction 00b disables, 10b selects first negative motion, 11b reserved
// RULE14 - hold bit zero: clear on servo-off, init, alarm, torque off, deviation clear, overtravel
// RULE15 - reported position is internal minus amount when report bit zero, else unmodified
// RULE16 - offset ramps in by first-order smoothing set by the time constant
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define BLC_OFS_SELECT      12'h000
`define BLC_OFS_AMOUNT      12'h004
`define BLC_OFS_TCONST      12'h008
`define BLC_OFS_EXPAND      12'h00c
`define BLC_OFS_CTRL        12'h010
`define BLC_OFS_CMD_POS     12'h014
`define BLC_OFS_ACT_POS     12'h018
`define BLC_OFS_STATUS      12'h01c
`define BLC_OFS_OFFSET      12'h020
`define BLC_OFS_REPORT      12'h024
`define BLC_OFS_CMD_OUT     12'h028

// ****************************************
// field positions
// ****************************************
`define BLC_SEL_DIR_LO      0
`define BLC_SEL_HOLD_BIT    2
`define BLC_EXP_REPORT_BIT  6
`define BLC_CTRL_SERVO_BIT  0
`define BLC_CTRL_MODE_LO    1
`define BLC_CTRL_CLEAR_BIT  3
`define BLC_CTRL_INIT_BIT   4
`define BLC_CTRL_ALARM_BIT  5
`define BLC_CTRL_STO_BIT    6
`define BLC_CTRL_OT_BIT     7

// ****************************************
// reset values and timing
// ****************************************
`define BLC_RST_SELECT      3'h0
`define BLC_RST_AMOUNT      32'h0000_0000
`define BLC_RST_TCONST      5'h00
`define BLC_RST_EXPAND      32'h0000_0000
`define BLC_RST_CTRL        8'h00
`define BLC_CLK_HZ          40000000

`endif

//--- blc_pkg.sv
// types for the backlash compensation block
package blc_pkg;

    typedef enum logic [1:0] {
        BLC_MODE_POS   = 2'b00,
        BLC_MODE_FULL  = 2'b01,
        BLC_MODE_VEL   = 2'b10,
        BLC_MODE_TRQ   = 2'b11
    } blc_mode_t;

    typedef enum logic [1:0] {
        BLC_DIR_OFF = 2'b00,
        BLC_DIR_POS = 2'b01,
        BLC_DIR_NEG = 2'b10,
        BLC_DIR_RSV = 2'b11
    } blc_dir_t;

    typedef enum logic [1:0] {
        BLC_ST_IDLE = 2'b00,
        BLC_ST_WAIT = 2'b01,
        BLC_ST_APPL = 2'b10,
        BLC_ST_REV  = 2'b11
    } blc_state_t;

endpackage : blc_pkg

//--- blc_smooth.sv
// first-order smoothing of the compensation offset
`timescale 1ns/10ps
`include "blc_cfg.svh"
module blc_smooth
    import blc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    input  wire logic [31:0] target,
    input  wire logic [4:0]  tconst,
    output logic      [31:0] value_q
);
    logic [31:0] diff;
    logic [31:0] step;

    assign diff = target - value_q;
    // step = diff >>> tconst (arithmetic shift), at least one unit toward the target
    always_comb begin
        step = 32'($signed(diff) >>> tconst);
        if (step == 32'h0000_0000 && diff != 32'h0000_0000) begin
            step = diff[31] ? 32'hffff_ffff : 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= 32'h0000_0000;
        end else if (ce) begin
            if (load) begin
                value_q <= load_val;
            end else begin
                value_q <= value_q + step; // [RULE16]
            end
        end
    end

    AST_SMOOTH_MOVES: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !load && value_q != target |=> value_q != $past(value_q)) // [RULE16]
        else $error("smoothed offset stalled");
endmodule : blc_smooth

//--- blc_apb.sv
// apb register slave for the backlash compensation block
`timescale 1ns/10ps
`include "blc_cfg.svh"
module blc_apb
    import blc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] stat_word,
    input  wire logic [31:0] offset_word,
    input  wire logic [31:0] report_word,
    input  wire logic [31:0] cmd_word,
    output logic      [31:0] prdata_q,
    output logic             pslverr_q,
    output logic             pready_q,
    output logic      [2:0]  select_q,
    output logic      [31:0] amount_q,
    output logic      [4:0]  tconst_q,
    output logic      [31:0] expand_q,
    output logic      [7:0]  ctrl_q,
    output logic      [31:0] cmd_pos_q,
    output logic      [31:0] act_pos_q
);
    logic        acc;
    logic        hit;
    logic [31:0] rd;

    // one wait state: pready rises in the second access cycle
    assign acc = psel && penable && !pready_q;

    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        unique case (paddr)
            `BLC_OFS_SELECT:  rd = {29'h0, select_q};
            `BLC_OFS_AMOUNT:  rd = amount_q;
            `BLC_OFS_TCONST:  rd = {27'h0, tconst_q};
            `BLC_OFS_EXPAND:  rd = expand_q;
            `BLC_OFS_CTRL:    rd = {24'h0, ctrl_q};
            `BLC_OFS_CMD_POS: rd = cmd_pos_q;
            `BLC_OFS_ACT_POS: rd = act_pos_q;
            `BLC_OFS_STATUS:  rd = stat_word;
            `BLC_OFS_OFFSET:  rd = offset_word;
            `BLC_OFS_REPORT:  rd = report_word;
            `BLC_OFS_CMD_OUT: rd = cmd_word;
            default:          hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= acc;
            pslverr_q <= acc && !hit;
            prdata_q  <= (acc && !pwrite) ? rd : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_q  <= `BLC_RST_SELECT;
            amount_q  <= `BLC_RST_AMOUNT;
            tconst_q  <= `BLC_RST_TCONST;
            expand_q  <= `BLC_RST_EXPAND;
            ctrl_q    <= `BLC_RST_CTRL;
            cmd_pos_q <= 32'h0000_0000;
            act_pos_q <= 32'h0000_0000;
        end else if (ce && acc && pwrite) begin
            unique case (paddr)
                `BLC_OFS_SELECT:  select_q  <= pwdata[2:0];
                `BLC_OFS_AMOUNT:  amount_q  <= pwdata;
                `BLC_OFS_TCONST:  tconst_q  <= pwdata[4:0];
                `BLC_OFS_EXPAND:  expand_q  <= pwdata;
                `BLC_OFS_CTRL:    ctrl_q    <= pwdata[7:0];
                `BLC_OFS_CMD_POS: cmd_pos_q <= pwdata;
                `BLC_OFS_ACT_POS: act_pos_q <= pwdata;
                default:          ;
            endcase
        end
    end
endmodule : blc_apb

//--- blc_top.sv
// backlash compensation for a position loop
`timescale 1ns/10ps
`include "blc_cfg.svh"
module blc_top
    import blc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] cmd_out_q,
    output logic      [31:0] report_pos_q,
    output logic      [31:0] offset_q
);
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [2:0]  select_q;
    logic [31:0] amount_q;
    logic [4:0]  tconst_q;
    logic [31:0] expand_q;
    logic [7:0]  ctrl_q;
    logic [31:0] cmd_pos_q;
    logic [31:0] act_pos_q;
    logic [31:0] stat_word;
    logic [31:0] smooth_q;

    blc_state_t  state_q;
    blc_dir_t    dir_q;
    logic        servo_q;
    logic [31:0] prev_cmd_q;
    logic [31:0] target_q;
    logic [31:0] base_q;
    logic        servo_on;
    logic        servo_off;
    logic        pos_mode;
    logic        hold;
    logic        clr_evt;
    logic        mv_pos;
    logic        mv_neg;
    logic        preset;
    blc_mode_t   mode;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // register file
    // ****************************************
    blc_apb u_apb (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .stat_word   (stat_word),
        .offset_word (offset_q),
        .report_word (report_pos_q),
        .cmd_word    (cmd_out_q),
        .prdata_q    (prdata_q),
        .pslverr_q   (pslverr_q),
        .pready_q    (pready_q),
        .select_q    (select_q),
        .amount_q    (amount_q),
        .tconst_q    (tconst_q),
        .expand_q    (expand_q),
        .ctrl_q      (ctrl_q),
        .cmd_pos_q   (cmd_pos_q),
        .act_pos_q   (act_pos_q)
    );

    assign stat_word = {24'h0, servo_q, 1'b0, dir_q, 2'b00, state_q};

    // ****************************************
    // decode
    // ****************************************
    assign mode      = blc_mode_t'(ctrl_q[`BLC_CTRL_MODE_LO +: 2]);
    assign pos_mode  = (mode == BLC_MODE_POS) || (mode == BLC_MODE_FULL); // [RULE1]
    assign hold      = select_q[`BLC_SEL_HOLD_BIT];
    assign servo_on  = ctrl_q[`BLC_CTRL_SERVO_BIT] && !servo_q;
    assign servo_off = !ctrl_q[`BLC_CTRL_SERVO_BIT] && servo_q;
    // clear events with hold bit zero; network init clears in both modes
    assign clr_evt   = ctrl_q[`BLC_CTRL_INIT_BIT] ||
                       (!hold && (servo_off || ctrl_q[`BLC_CTRL_ALARM_BIT] || ctrl_q[`BLC_CTRL_STO_BIT] ||
                                  ctrl_q[`BLC_CTRL_CLEAR_BIT] || ctrl_q[`BLC_CTRL_OT_BIT])); // [RULE14]
    assign mv_pos    = $signed(cmd_pos_q - prev_cmd_q) > 0;
    assign mv_neg    = $signed(cmd_pos_q - prev_cmd_q) < 0;
    assign preset    = clr_evt && (state_q == BLC_ST_APPL); // [RULE10]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            servo_q    <= 1'b0;
            prev_cmd_q <= 32'h0000_0000;
        end else if (ce) begin
            servo_q    <= ctrl_q[`BLC_CTRL_SERVO_BIT];
            prev_cmd_q <= cmd_pos_q;
        end
    end

    // ****************************************
    // direction latch
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= BLC_DIR_OFF;
        end else if (ce && servo_on) begin
            dir_q <= blc_dir_t'(select_q[`BLC_SEL_DIR_LO +: 2]); // [RULE3]
        end
    end

    // ****************************************
    // compensation sequence
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= BLC_ST_IDLE;
            target_q <= 32'h0000_0000;
        end else if (ce) begin
            if (clr_evt) begin
                state_q  <= BLC_ST_IDLE; // [RULE10] [RULE14]
                target_q <= 32'h0000_0000;
            end else if (servo_on && state_q == BLC_ST_IDLE) begin
                state_q  <= BLC_ST_WAIT; // [RULE11]
            end else if (servo_q && pos_mode) begin // [RULE1] [RULE5]
                unique case (state_q)
                    BLC_ST_WAIT: begin
                        if ((dir_q == BLC_DIR_POS && mv_pos) || (dir_q == BLC_DIR_NEG && mv_neg)) begin
                            state_q  <= BLC_ST_APPL; // [RULE2] [RULE7] [RULE13]
                            target_q <= amount_q;
                        end
                    end
                    BLC_ST_APPL: begin
                        if ((dir_q == BLC_DIR_POS && mv_neg) || (dir_q == BLC_DIR_NEG && mv_pos)) begin
                            state_q  <= BLC_ST_REV; // [RULE8]
                            target_q <= 32'h0000_0000;
                        end
                    end
                    BLC_ST_REV: begin
                        if ((dir_q == BLC_DIR_POS && mv_pos) || (dir_q == BLC_DIR_NEG && mv_neg)) begin
                            state_q  <= BLC_ST_APPL; // [RULE9]
                            target_q <= amount_q;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // smoothing and outputs
    // ****************************************
    blc_smooth u_smooth (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .load     (clr_evt),
        .load_val (32'h0000_0000),
        .target   (target_q),
        .tconst   (tconst_q),
        .value_q  (smooth_q)
    );

    // preset base absorbs the offset in the applied state so the command does not jump on clear there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= 32'h0000_0000;
        end else if (ce && preset) begin
            base_q <= base_q + smooth_q; // [RULE10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_out_q    <= 32'h0000_0000;
            report_pos_q <= 32'h0000_0000;
            offset_q     <= 32'h0000_0000;
        end else if (ce) begin
            cmd_out_q    <= cmd_pos_q + base_q + smooth_q; // [RULE16]
            offset_q     <= smooth_q;
            report_pos_q <= expand_q[`BLC_EXP_REPORT_BIT] ? act_pos_q
                                                           : act_pos_q - smooth_q; // [RULE6] [RULE15]
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_DIR_ONLY_AT_ON: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !servo_on |=> $stable(dir_q)) // [RULE3]
        else $error("direction changed outside servo-on");
    AST_NO_MOVE_OFF_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && servo_q && !pos_mode && !clr_evt && !servo_on |=> $stable(state_q)) // [RULE1]
        else $error("sequence advanced outside position control");
    AST_HOLD_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
        ce && hold && servo_off && !ctrl_q[`BLC_CTRL_INIT_BIT] |=> $stable(target_q)) // [RULE11]
        else $error("hold mode lost state");
    AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr_evt |=> state_q == BLC_ST_IDLE && target_q == 32'h0 && smooth_q == 32'h0) // [RULE14]
        else $error("clear event did not clear");
    AST_FIRST_APPLY: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state_q == BLC_ST_WAIT && servo_q && pos_mode && !clr_evt && dir_q == BLC_DIR_POS && mv_pos
        |=> state_q == BLC_ST_APPL && target_q == $past(amount_q)) // [RULE2] [RULE7]
        else $error("first positive motion not compensated");
    AST_NO_OPPOSITE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state_q == BLC_ST_WAIT && dir_q == BLC_DIR_POS && mv_neg && !servo_on |=> state_q != BLC_ST_APPL) // [RULE7]
        else $error("opposite first motion compensated");
    AST_REVERSE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state_q == BLC_ST_APPL && servo_q && pos_mode && !clr_evt && dir_q == BLC_DIR_NEG && mv_pos
        |=> state_q == BLC_ST_REV && target_q == 32'h0) // [RULE8]
        else $error("reverse compensation missing");
    AST_REPEAT: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state_q == BLC_ST_APPL && !clr_evt && dir_q == BLC_DIR_POS && mv_pos |=> state_q == BLC_ST_APPL) // [RULE9]
        else $error("repeat motion recompensated");
    AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        ce && dir_q == BLC_DIR_OFF && state_q == BLC_ST_WAIT && !servo_on |=> state_q != BLC_ST_APPL) // [RULE13]
        else $error("disabled direction applied");
    AST_REPORT: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !expand_q[`BLC_EXP_REPORT_BIT] |=> report_pos_q == $past(act_pos_q) - $past(smooth_q)) // [RULE15]
        else $error("reported position wrong");

    COV_APPLY: cover property (@(posedge pclk) state_q == BLC_ST_WAIT ##1 state_q == BLC_ST_APPL);
    COV_REV: cover property (@(posedge pclk) state_q == BLC_ST_APPL ##1 state_q == BLC_ST_REV);
    COV_PRESET: cover property (@(posedge pclk) preset);
    COV_MODE_SWITCH: cover property (@(posedge pclk) state_q == BLC_ST_APPL && !pos_mode);
endmodule : blc_top

//--- blc_host.sv
// apb master standing for the host motion controller
`timescale 1ns/10ps
module blc_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req,
    input  wire logic        wr_en,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [31:0] rdata,
    output logic             err,
    output logic             done
);
    logic [1:0] st_q;

    // ****************************************
    // setup, access, wait for pready, release
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= 2'h0;
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 12'h000;
            pwdata  <= 32'h0000_0000;
            rdata   <= 32'h0000_0000;
            err     <= 1'b0;
            done    <= 1'b0;
        end else begin
            case (st_q)
                2'h0: if (req) begin
                    psel   <= 1'b1;
                    pwrite <= wr_en;
                    paddr  <= addr;
                    pwdata <= wdata;
                    st_q   <= 2'h1;
                end
                2'h1: begin
                    penable <= 1'b1;
                    st_q    <= 2'h2;
                end
                2'h2: if (pready) begin
                    // released address and data lines show the inverse of the last value
                    psel    <= 1'b0;
                    penable <= 1'b0;
                    paddr   <= ~paddr;
                    pwdata  <= ~pwdata;
                    rdata   <= prdata;
                    err     <= pslverr;
                    done    <= 1'b1;
                    st_q    <= 2'h3;
                end
                default: begin
                    done <= 1'b0;
                    if (!req) begin
                        st_q <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule : blc_host

//--- testbench.sv
// self-checking bench for the backlash compensation block
`timescale 1ns/10ps
`include "blc_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, addr;
    logic [31:0] pwdata, prdata, cmd_out_q, report_pos_q, offset_q, wdata, rdata;
    logic        req, wr_en, err, done;
    logic [31:0] p, base_e;
    logic [31:0] amt = 32'h0000_0040;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    blc_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_out_q(cmd_out_q), .report_pos_q(report_pos_q), .offset_q(offset_q));
    blc_host i_host (.pclk(pclk), .presetn(presetn), .req(req), .wr_en(wr_en), .addr(addr), .wdata(wdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .rdata(rdata), .err(err), .done(done));

    // ****************************************
    // clock, timeout, closing report
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // bus and motion tasks
    // ****************************************
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        req   <= 1'b1;
        wr_en <= w;
        addr  <= a;
        wdata <= d;
        @(posedge pclk);
        while (done !== 1'b1) begin
            @(posedge pclk);
        end
        req <= 1'b0;
        @(posedge pclk);
    endtask : bus

    task automatic mv(input logic [31:0] np);
        p = np;
        bus(1'b1, `BLC_OFS_CMD_POS, np);
        repeat (4) @(posedge pclk);
    endtask : mv

    task automatic chk_out(input logic [31:0] off);
        `CHK(offset_q, off)
        `CHK(cmd_out_q, p + base_e + off)
    endtask : chk_out

    task automatic servo(input logic [7:0] c);
        bus(1'b1, `BLC_OFS_CTRL, {24'h000000, c});
        repeat (4) @(posedge pclk);
    endtask : servo

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        ce      = 1'b1;
        req     = 1'b0;
        wr_en   = 1'b0;
        addr    = 12'h000;
        wdata   = 32'h0000_0000;
        base_e  = 32'h0000_0000;
        p       = 32'h0000_0100;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b0, 12'h040, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rdata, 32'h0000_0000)
        // settings written with the servo off, hold bit zero; select and expand are later rewritten with the servo on
        bus(1'b1, `BLC_OFS_SELECT, 32'h0000_0001);
        bus(1'b1, `BLC_OFS_AMOUNT, amt);
        bus(1'b1, `BLC_OFS_CMD_POS, p);
        servo(8'h01);
        mv(32'h0000_00f0);
        chk_out(32'h0000_0000);
        mv(32'h0000_0110);
        chk_out(amt);
        mv(32'h0000_0120);
        chk_out(amt);
        bus(1'b1, `BLC_OFS_ACT_POS, 32'h0000_0500);
        repeat (4) @(posedge pclk);
        `CHK(report_pos_q, 32'h0000_0500 - amt)
        bus(1'b1, `BLC_OFS_EXPAND, 32'h0000_0040);
        repeat (4) @(posedge pclk);
        `CHK(report_pos_q, 32'h0000_0500)
        servo(8'h05);
        mv(32'h0000_0100);
        `CHK(offset_q, amt)
        servo(8'h07);
        mv(32'h0000_0130);
        `CHK(offset_q, amt)
        servo(8'h03);
        mv(32'h0000_0110);
        chk_out(32'h0000_0000);
        mv(32'h0000_0118);
        chk_out(amt);
        bus(1'b1, `BLC_OFS_SELECT, 32'h0000_0002);
        bus(1'b0, `BLC_OFS_STATUS, 32'h0000_0000);
        `CHK(rdata[5:4], 2'b01)
        servo(8'h00);
        base_e = amt;
        chk_out(32'h0000_0000);
        servo(8'h01);
        bus(1'b0, `BLC_OFS_STATUS, 32'h0000_0000);
        `CHK(rdata[5:4], 2'b10)
        `CHK(rdata[1:0], 2'b01)
        mv(32'h0000_0130);
        chk_out(32'h0000_0000);
        mv(32'h0000_0128);
        chk_out(amt);
        servo(8'h00);
        base_e = base_e + amt;
        bus(1'b1, `BLC_OFS_SELECT, 32'h0000_0006);
        servo(8'h01);
        mv(32'h0000_0120);
        chk_out(amt);
        servo(8'h00);
        `CHK(offset_q, amt)
        servo(8'h01);
        bus(1'b0, `BLC_OFS_STATUS, 32'h0000_0000);
        `CHK(rdata[1:0], 2'b10)
        mv(32'h0000_0130);
        chk_out(32'h0000_0000);
        servo(8'h00);
        bus(1'b1, `BLC_OFS_SELECT, 32'h0000_0001);
        for (int i = 3; i < 8; i++) begin
            servo(8'h01);
            mv(p + 32'h0000_0010);
            `CHK(offset_q, amt)
            servo(8'h01 | (8'h01 << i));
            `CHK(offset_q, 32'h0000_0000)
            servo(8'h00);
        end
        for (int s = 0; s < 4; s += 3) begin
            bus(1'b1, `BLC_OFS_SELECT, s);
            servo(8'h01);
            mv(p + 32'h0000_0010);
            mv(p - 32'h0000_0008);
            `CHK(offset_q, 32'h0000_0000)
            servo(8'h00);
        end
        bus(1'b1, `BLC_OFS_SELECT, 32'h0000_0001);
        bus(1'b1, `BLC_OFS_TCONST, 32'h0000_0001);
        servo(8'h01);
        bus(1'b1, `BLC_OFS_CMD_POS, p + 32'h0000_0010);
        for (int n = 0; n < 20 && offset_q === 32'h0000_0000; n++) begin
            @(posedge pclk);
        end
        `CHK(offset_q, amt >> 1)
        @(posedge pclk);
        `CHK(offset_q, amt - (amt >> 2))
        // clock enable low freezes the ramp at its next value
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(offset_q, amt - (amt >> 3))
        ce <= 1'b1;
        complete_run();
    end
endmodule : testbench
